// ---- verilog/ccf_host.sv ----
`include "ccf_defines.svh"

// Summary of operation
// - A side starts a character only when it sees the shared line high.
// - A character is ten bit periods: a low start bit, eight data bits and a parity bit.
// - The parity bit makes the count of ones over data and parity even.
// - After a falling edge the receiver confirms the start bit is still low before 0.7 etu.
// - The receiver samples bit n at n + 0.5 etu after the start edge, within 0.2 etu.
// - The transmitter starts bit n at n etu after the start edge, within 0.2 etu.
// - Start edges of consecutive characters are 10 etu plus a guardtime apart.
// - Nobody drives the line during the guardtime; it stays high.
// - Multi-byte data goes over the line most significant byte first.
// - Bit order inside a byte follows the convention the card announced at reset.
// - Both protocol types use this same physical layer and frame.
module ccf_host (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  clk_div_i,
    input  wire logic [11:0] etu_clks_i,
    input  wire logic [7:0]  guard_etu_i,
    input  wire logic        conv_inv_i,
    input  wire logic        tx_valid_i,
    input  wire logic [7:0]  tx_data_i,
    output logic             tx_ready_o,
    output logic             rx_valid_o,
    output logic [7:0]       rx_data_o,
    output logic             rx_par_err_o,
    output logic             busy_o,
    output logic             card_clk_o,
    input  wire logic        io_i,
    output logic             io_o,
    output logic             io_oe_o
);

    ccf_pkg::ccf_state_e state_q;
    logic [7:0]  dcnt_q;
    logic [7:0]  dcnt_d;
    logic        cclk_en;
    logic        card_clk_q;
    logic [11:0] ph_q;
    logic        etu_end;
    logic        mid_tick;
    logic        io_q;
    logic        fall;
    logic        rx_edge;
    logic        accept;
    logic        start_evt;
    logic [3:0]  bit_q;
    logic [8:0]  g_q;
    logic [8:0]  guard_eff;
    logic        tx_guard_q;
    logic [8:0]  tx_line;
    logic [8:0]  tx_sh_q;
    logic        io_oe_q;
    logic [8:0]  rx_sh_q;
    logic [8:0]  rx_full;
    logic [7:0]  rx_dec;
    logic        rx_par;
    logic        rx_valid_q;
    logic [7:0]  rx_data_q;
    logic        rx_perr_q;

    // Card clock divider: one enable per card clock period
    assign cclk_en = (dcnt_q >= clk_div_i - 8'h01);
    assign dcnt_d  = cclk_en ? 8'h00 : dcnt_q + 8'h01;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            dcnt_q     <= 8'h00;
            card_clk_q <= 1'b0;
        end
        else
        begin
            dcnt_q     <= dcnt_d;
            card_clk_q <= (dcnt_d < {1'b0, clk_div_i[7:1]});
        end
    end

    // Etu phase counts card clocks, restarted on every start edge
    assign etu_end  = cclk_en && (ph_q >= etu_clks_i - 12'h001);
    assign mid_tick = cclk_en && (ph_q == {1'b0, etu_clks_i[11:1]});

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            ph_q <= 12'h000;
        else if (start_evt)
            ph_q <= 12'h000;
        else if (cclk_en)
            ph_q <= etu_end ? 12'h000 : ph_q + 12'h001;
    end

    // Line edge detect; io_i is already in this clock domain
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            io_q <= 1'b1;
        else
            io_q <= io_i;
    end

    assign fall    = io_q && !io_i;
    assign rx_edge = fall && ((state_q == ccf_pkg::ST_IDLE) ||
                              (state_q == ccf_pkg::ST_GUARD && !tx_guard_q));
    // Line must read high twice before a send may start
    assign tx_ready_o = (state_q == ccf_pkg::ST_IDLE) && io_i && io_q;
    // Bytes leave in the order offered, so the user sets byte order
    assign accept    = tx_valid_i && tx_ready_o;
    assign start_evt = accept || rx_edge;
    assign busy_o    = (state_q != ccf_pkg::ST_IDLE);

    // Guardtime never below the floor, whatever software asks
    assign guard_eff = ({1'b0, guard_etu_i} < `CCF_MIN_GUARD_ETU) ?
                       `CCF_MIN_GUARD_ETU : {1'b0, guard_etu_i};

    // Convention mapping per bit: inverse means MSB first and inverted levels
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_conv
            assign tx_line[gi] = conv_inv_i ? ~tx_data_i[7-gi] : tx_data_i[gi];
            assign rx_dec[gi]  = conv_inv_i ? ~rx_full[7-gi] : rx_full[gi];
        end
    endgenerate

    assign tx_line[8] = conv_inv_i ? ~(^tx_data_i) : (^tx_data_i);
    assign rx_full    = {io_i, rx_sh_q[8:1]};
    assign rx_par     = conv_inv_i ? ~rx_full[8] : rx_full[8];

    // Frame sequencer, same frame for either protocol type
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            state_q <= ccf_pkg::ST_IDLE;
        else
        begin
            unique case (state_q)
                ccf_pkg::ST_IDLE:
                    if (rx_edge)
                        state_q <= ccf_pkg::ST_CONF;
                    else if (accept)
                        state_q <= ccf_pkg::ST_TXBITS;
                ccf_pkg::ST_CONF:
                    if (mid_tick)
                        state_q <= io_i ? ccf_pkg::ST_IDLE : ccf_pkg::ST_RXBITS;
                ccf_pkg::ST_RXBITS:
                    if (mid_tick && bit_q == `CCF_LAST_BIT)
                        state_q <= ccf_pkg::ST_GUARD;
                ccf_pkg::ST_TXBITS:
                    if (etu_end && bit_q == `CCF_LAST_BIT)
                        state_q <= ccf_pkg::ST_GUARD;
                ccf_pkg::ST_GUARD:
                    if (rx_edge)
                        state_q <= ccf_pkg::ST_CONF;
                    else if (g_q == 9'h000)
                        state_q <= ccf_pkg::ST_IDLE;
            endcase
        end
    end

    // Bit rank within the frame
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            bit_q <= 4'h0;
        else if (start_evt)
            bit_q <= 4'h0;
        else if (state_q == ccf_pkg::ST_CONF && mid_tick)
            bit_q <= 4'h1;
        else if (state_q == ccf_pkg::ST_RXBITS && mid_tick)
            bit_q <= bit_q + 4'h1;
        else if (state_q == ccf_pkg::ST_TXBITS && etu_end)
            bit_q <= bit_q + 4'h1;
    end

    // Guard countdown; receive enters half an etu early, so one extra etu
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            g_q        <= 9'h000;
            tx_guard_q <= 1'b0;
        end
        else if (state_q == ccf_pkg::ST_RXBITS && mid_tick && bit_q == `CCF_LAST_BIT)
        begin
            g_q        <= guard_eff + 9'h001;
            tx_guard_q <= 1'b0;
        end
        else if (state_q == ccf_pkg::ST_TXBITS && etu_end && bit_q == `CCF_LAST_BIT)
        begin
            g_q        <= guard_eff;
            tx_guard_q <= 1'b1;
        end
        else if (state_q == ccf_pkg::ST_GUARD && etu_end && g_q != 9'h000)
            g_q <= g_q - 9'h001;
    end

    // Transmit shifter; open drain, so only zeros are driven
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            tx_sh_q <= 9'h000;
            io_oe_q <= 1'b0;
        end
        else if (accept)
        begin
            tx_sh_q <= tx_line;
            io_oe_q <= 1'b1;
        end
        else if (state_q == ccf_pkg::ST_TXBITS && etu_end)
        begin
            tx_sh_q <= {1'b0, tx_sh_q[8:1]};
            // Release after parity so the guardtime stays high
            io_oe_q <= (bit_q == `CCF_LAST_BIT) ? 1'b0 : ~tx_sh_q[0];
        end
    end

    assign io_o    = 1'b0;
    assign io_oe_o = io_oe_q;

    // Receive shifter, one sample at each bit centre
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            rx_sh_q <= 9'h000;
        else if (state_q == ccf_pkg::ST_RXBITS && mid_tick)
            rx_sh_q <= rx_full;
    end

    // Received byte, parity flag and one-cycle strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= 8'h00;
            rx_perr_q  <= 1'b0;
        end
        else
        begin
            rx_valid_q <= 1'b0;
            if (state_q == ccf_pkg::ST_RXBITS && mid_tick && bit_q == `CCF_LAST_BIT)
            begin
                rx_valid_q <= 1'b1;
                rx_data_q  <= rx_dec;
                rx_perr_q  <= ^{rx_par, rx_dec};
            end
        end
    end

    assign rx_valid_o   = rx_valid_q;
    assign rx_data_o    = rx_data_q;
    assign rx_par_err_o = rx_perr_q;
    assign card_clk_o   = card_clk_q;

    // Checker helpers: etu count in a send, etu since last start edge
    logic [7:0] tx_len_q;
    logic [7:0] sp_q;
    logic       seen_q;

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            tx_len_q <= 8'h00;
        else if (accept)
            tx_len_q <= 8'h00;
        else if (state_q == ccf_pkg::ST_TXBITS && etu_end)
            tx_len_q <= tx_len_q + 8'h01;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            sp_q   <= 8'h00;
            seen_q <= 1'b0;
        end
        else if (start_evt)
        begin
            sp_q   <= 8'h00;
            seen_q <= 1'b1;
        end
        else
        begin
            if (etu_end && sp_q != 8'hFF)
                sp_q <= sp_q + 8'h01;
            // A glitch that failed confirmation is no character
            if (state_q == ccf_pkg::ST_CONF && mid_tick && io_i)
                seen_q <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    chk_line_high: assert property (accept |-> io_i && io_q)
        else $error("send started with line low");
    chk_frame_len: assert property ($fell(state_q == ccf_pkg::ST_TXBITS) |-> tx_len_q == `CCF_FRAME_ETU)
        else $error("sent frame not ten etu");
    chk_tx_parity: assert property (accept |=> (^tx_sh_q) == conv_inv_i)
        else $error("sent parity not even");
    chk_start_conf: assert property (state_q == ccf_pkg::ST_CONF && mid_tick && io_i |=>
        state_q == ccf_pkg::ST_IDLE)
        else $error("false start bit accepted");
    chk_rx_centre: assert property ($changed(rx_sh_q) |-> $past(mid_tick))
        else $error("sample off bit centre");
    chk_tx_edges: assert property ($changed(io_oe_q) |-> $past(etu_end || accept))
        else $error("line edge off etu boundary");
    chk_char_space: assert property (accept && seen_q |-> sp_q >= `CCF_MIN_SPACE_ETU)
        else $error("characters too close");
    chk_guard_quiet: assert property (state_q == ccf_pkg::ST_GUARD |-> !io_oe_q)
        else $error("line driven in guardtime");
    chk_phase_restart: assert property (start_evt |=> ph_q == 12'h000)
        else $error("etu phase not restarted");

    cov_tx_frame: cover property (accept ##1 state_q == ccf_pkg::ST_TXBITS);
    cov_rx_good: cover property (rx_valid_o && !rx_par_err_o);
    cov_rx_perr: cover property (rx_valid_o && rx_par_err_o);
    cov_rx_inverse: cover property (rx_valid_o && conv_inv_i);

endmodule : ccf_host

// ---- verilog/ccf_defines.svh ----
`ifndef CCF_DEFINES_SVH
`define CCF_DEFINES_SVH

// Character frame shape
`define CCF_DATA_BITS     4'd8
`define CCF_LAST_BIT      4'd9
`define CCF_FRAME_ETU     8'd10

// Guardtime floor in etu; 10 + 2 gives the 12 etu character spacing floor
`define CCF_MIN_GUARD_ETU 9'd2
`define CCF_MIN_SPACE_ETU 8'd12

// Divider defaults, sys clocks per card clock and card clocks per etu
`define CCF_DEF_CLK_DIV   8'h04
`define CCF_DEF_ETU_CLKS  12'h174

`endif

// ---- verilog/ccf_pkg.sv ----
package ccf_pkg;

    // Link sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CONF,
        ST_RXBITS,
        ST_TXBITS,
        ST_GUARD
    } ccf_state_e;

endpackage : ccf_pkg

// ---- test/ccf_card_model.sv ----
// Behavioural card at the far end of the shared line; counts sys cycles per etu
module ccf_card_model #(
    parameter int ETU_SYS = 16
) (
    input  wire logic clk_sys_i,
    input  wire logic io_i,
    input  wire logic conv_inv_i,
    output logic      card_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] rx_q[$];
    logic       perr_q[$];
    time        edge_q[$];
    bit         sending;
    logic [9:0] lb;
    logic [7:0] dd;

    // Line released at start, pull-up gives the idle high level
    initial
    begin
        card_oe_o = 1'b0;
        sending   = 1'b0;
    end

    // Receiver, one frame shape for both protocol types; deaf while sending
    always
    begin
        @(negedge io_i);
        if (!sending)
        begin
            edge_q.push_back($time);
            repeat (ETU_SYS / 2) @(posedge clk_sys_i);
            if (io_i === 1'b0)
            begin
                for (int k = 1; k < 10; k++)
                begin
                    repeat (ETU_SYS) @(posedge clk_sys_i);
                    lb[k] = io_i ^ conv_inv_i;
                end
                for (int k = 1; k < 9; k++)
                    dd[conv_inv_i ? 8 - k : k - 1] = lb[k];
                rx_q.push_back(dd);
                perr_q.push_back(^lb[9:1]);
            end
        end
    end

    // Whole frame; skew lengthens or shortens the start bit so every later edge moves
    task automatic send_byte(input logic [7:0] d, input int skew, input bit bad);
        logic [9:0] lv;
        sending = 1'b1;
        while (io_i !== 1'b1) @(posedge clk_sys_i);
        lv[0] = 1'b0;
        for (int k = 1; k < 9; k++)
            lv[k] = d[conv_inv_i ? 8 - k : k - 1] ^ conv_inv_i;
        lv[9] = ^d ^ bad ^ conv_inv_i;
        for (int k = 0; k < 10; k++)
        begin
            card_oe_o <= ~lv[k];
            repeat (k == 0 ? ETU_SYS + skew : ETU_SYS) @(posedge clk_sys_i);
        end
        card_oe_o <= 1'b0;
        repeat (2 * ETU_SYS) @(posedge clk_sys_i);
        sending = 1'b0;
    endtask : send_byte

    // Short low pulse, too short to pass as a start bit
    task automatic glitch(input int n);
        sending = 1'b1;
        card_oe_o <= 1'b1;
        repeat (n) @(posedge clk_sys_i);
        card_oe_o <= 1'b0;
        @(posedge clk_sys_i);
        sending = 1'b0;
    endtask : glitch

endmodule : ccf_card_model

// ---- test/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int ETU = 16; // Two sys clocks per card clock, eight card clocks per etu

    logic       clk_sys_i, rst_i, conv_inv, tx_valid, tx_ready, rx_valid, rx_perr, busy;
    logic       host_oe, host_do, card_oe, card_clk, io;
    logic [7:0] tx_data, rx_data, guard;
    int         miscompares, check_count;

    // Open-drain line with pull-up
    assign io = ~card_oe & (host_oe ? host_do : 1'b1);

    ccf_host u_ccf_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_div_i(8'h02), .etu_clks_i(12'h008),
        .guard_etu_i(guard), .conv_inv_i(conv_inv), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_par_err_o(rx_perr),
        .busy_o(busy), .card_clk_o(card_clk), .io_i(io), .io_o(host_do), .io_oe_o(host_oe));

    ccf_card_model #(.ETU_SYS(ETU)) u_ccf_card_model (.clk_sys_i(clk_sys_i), .io_i(io),
        .conv_inv_i(conv_inv), .card_oe_o(card_oe));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check1

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // Offer one byte, hold until taken, then let an edge pass
    task automatic host_send(input logic [7:0] d);
        tx_valid <= 1'b1;
        tx_data  <= d;
        for (int i = 0; i < 600; i++)
        begin
            @(posedge clk_sys_i);
            if (tx_ready === 1'b1)
                break;
        end
        tx_valid <= 1'b0;
        @(posedge clk_sys_i);
    endtask : host_send

    // Two bytes of one word, high byte first, with start spacing checked
    task automatic host_to_card;
        time dt;
        u_ccf_card_model.rx_q.delete();
        u_ccf_card_model.perr_q.delete();
        u_ccf_card_model.edge_q.delete();
        host_send(8'h55);
        host_send(8'hAA);
        for (int i = 0; i < 400 && u_ccf_card_model.rx_q.size() < 2; i++) @(posedge clk_sys_i);
        check8(u_ccf_card_model.rx_q[0], 8'h55);
        check8(u_ccf_card_model.rx_q[1], 8'hAA);
        check1(u_ccf_card_model.perr_q[0] | u_ccf_card_model.perr_q[1], 1'b0);
        dt = u_ccf_card_model.edge_q[1] - u_ccf_card_model.edge_q[0];
        check1((dt >= 1920) && (dt <= 1960), 1'b1);
        repeat (3 * ETU) @(posedge clk_sys_i);
    endtask : host_to_card

    // Card frame with edge skew or bad parity, judged at the host outputs
    task automatic card_to_host(input logic [7:0] d, input int skew, input bit bad);
        fork
            u_ccf_card_model.send_byte(d, skew, bad);
        join_none
        for (int i = 0; i < 400 && rx_valid !== 1'b1; i++) @(posedge clk_sys_i);
        check1(rx_valid, 1'b1);
        check8(rx_data, d);
        check1(rx_perr, bad);
        wait fork;
    endtask : card_to_host

    // All-zero byte keeps the line low for the whole frame, so its length shows
    task automatic frame_len;
        int n;
        int hi;
        host_send(8'h00);
        check1(busy, 1'b1);
        n = 0;
        while (host_oe === 1'b1 && n < 400)
        begin
            n++;
            @(posedge clk_sys_i);
        end
        check8(n[7:0], 8'hA0);
        // Card clock: eight high phases in one etu of sys cycles
        hi = 0;
        repeat (ETU)
        begin
            @(posedge clk_sys_i);
            if (card_clk === 1'b1)
                hi++;
        end
        check8(hi[7:0], 8'h08);
        repeat (3 * ETU) @(posedge clk_sys_i);
        check1(busy, 1'b0);
    endtask : frame_len

    // Low pulse under half an etu: no send while low, no byte afterwards
    task automatic glitch_drop;
        int seen;
        seen = 0;
        fork
            u_ccf_card_model.glitch(4);
        join_none
        repeat (2) @(posedge clk_sys_i);
        check1(tx_ready, 1'b0);
        for (int i = 0; i < 200; i++)
        begin
            @(posedge clk_sys_i);
            if (rx_valid === 1'b1)
                seen++;
        end
        check1(seen != 0, 1'b0);
    endtask : glitch_drop

    // Run time is a few tens of microseconds
    initial
    begin
        #300us;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        rst_i       = 1'b1;
        conv_inv    = 1'b0;
        tx_valid    = 1'b0;
        tx_data     = 8'h00;
        guard       = 8'h02;
        miscompares = 0;
        check_count = 0;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        frame_len();
        glitch_drop();
        for (int c = 0; c < 2; c++)
        begin
            conv_inv <= c[0];
            // Zero guard in the second pass; the floor must keep the 12 etu spacing
            guard    <= c[0] ? 8'h00 : 8'h02;
            @(posedge clk_sys_i);
            host_to_card();
            card_to_host(8'hF0, 0, 1'b0);
            card_to_host(8'h0F, 3, 1'b0);
            card_to_host(8'hA5, -3, 1'b0);
            card_to_host(8'h3C, 0, 1'b1);
        end
        print_verdict();
    end

endmodule : testbench
